// ### include/crod_pkg.sv
package crod_pkg;
   // Option byte 1 field positions
   localparam int OPT_PKG_POS     = 7;
   localparam int OPT_RSTLEN_POS  = 6;
   localparam int OPT_SRC_HI      = 5;
   localparam int OPT_SRC_LO      = 4;
   localparam int OPT_RANGE_HI    = 3;
   localparam int OPT_RANGE_LO    = 1;
   localparam int OPT_PLL_DISABLE_POS  = 0;
   // Reset values of the decoded outputs (byte at erased default)
   localparam logic [7:0] OPT1_RESET_VALUE = 8'hFF;
   // Stabilisation counts in CPU cycles
   localparam int LONG_STAB_CYCLES  = 4096;
   localparam int SHORT_STAB_CYCLES = 256;
   localparam int STAB_CNT_W        = 13;
   typedef enum logic [1:0] {
      CROD_SRC_RESONATOR = 2'h0,
      CROD_SRC_RESERVED  = 2'h1,
      CROD_SRC_INT_RC    = 2'h2,
      CROD_SRC_EXTERNAL  = 2'h3
   } crod_src_t;
   typedef enum logic [2:0] {
      CROD_RNG_1_2   = 3'h0,
      CROD_RNG_2_4   = 3'h1,
      CROD_RNG_4_8   = 3'h2,
      CROD_RNG_8_16  = 3'h3
   } crod_rng_t;
   typedef enum logic [1:0] {
      CROD_ST_RUN   = 2'h0,
      CROD_ST_STAB  = 2'h1
   } crod_state_t;
endpackage

// ### design/crod_stab_counter.sv
`timescale 1ns/10ps
`default_nettype none
module crod_stab_counter
   import crod_pkg::*;
(
   // Clock and control
   input  wire logic                  clk,
   input  wire logic                  start,
   input  wire logic [STAB_CNT_W-1:0] loadCount,
   // Status
   output logic                       busy
);
   logic [STAB_CNT_W-1:0] cnt_reg;
   always_ff @(posedge clk) begin
      if (start) begin
         cnt_reg <= loadCount;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'h1;
      end
   end
   assign busy = (cnt_reg != '0);
endmodule
`default_nettype wire

// ### design/crod_option_decoder.sv
// Functional notes
// R01: Reset phase lasts 4096 cycles when length bit is 0, 256 when 1.
// R02: Halt exit uses the same selected stabilisation count as reset.
// R03: Programmer advised to choose 4096 cycles with a resonator.
// R04: Clock source from two-bit field: resonator, reserved, internal RC, external.
// R05: Resonator drive current from three-bit range field.
// R06: External clock forces range to the 2-4 MHz setting.
// R07: PLL times two enabled when disable bit is 0, bypassed when 1.
// R08: Programmer must not enable PLL with internal RC oscillator.
// R09: Programmer enables PLL only with 2-4 MHz range.
// R10: Package selection comes from the top option bit.
// R11: Unbonded pads are input pull-up after reset; software keeps them.
// R12: Readout protection encoding is inverted in ROM parts against Flash.
// R13: Option bytes have no memory address; only programming tool reaches them.
// R14: Decoded settings latch during reset and stay stable until next reset.
`timescale 1ns/10ps
`default_nettype none
module crod_option_decoder
   import crod_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Option byte from non-volatile storage, no bus address
   input  wire logic [7:0]          optionByte,
   input  wire logic                romPart,
   input  wire logic                readoutProtRaw,
   // Halt mode handshake from the core
   input  wire logic                haltWake,
   // Decoded settings
   output logic                     package_select_bit,
   output logic                     reset_length_select,
   output crod_src_t                clock_source_type,
   output crod_rng_t                resonator_drive_range,
   output logic                     pll_disable,
   output logic                     pllEnable,
   output logic                     readoutProtEnable,
   output logic                     unbondedPullUp,
   // Stabilisation status
   output logic                     cpuHold
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]            opt_reg;
   logic                  rdp_reg;
   crod_state_t           state_reg;
   crod_state_t           state_next;
   logic                  stabBusy;
   logic                  stabStart;
   logic [STAB_CNT_W-1:0] stabLoad;
   wire                   rstLenBit  = opt_reg[OPT_RSTLEN_POS];
   wire [1:0]             srcField   = opt_reg[OPT_SRC_HI:OPT_SRC_LO];
   wire [2:0]             rangeField = opt_reg[OPT_RANGE_HI:OPT_RANGE_LO];
   // Raw option fields at the pins, read by the checks against the latched values
   wire                   pkgRaw     = optionByte[OPT_PKG_POS];
   wire                   rstLenRaw  = optionByte[OPT_RSTLEN_POS];
   wire [1:0]             srcRaw     = optionByte[OPT_SRC_HI:OPT_SRC_LO];
   wire [2:0]             rangeRaw   = optionByte[OPT_RANGE_HI:OPT_RANGE_LO];
   wire                   pllOffRaw  = optionByte[OPT_PLL_DISABLE_POS];
   wire [STAB_CNT_W-1:0]  stabLen    = rstLenBit ? STAB_CNT_W'(SHORT_STAB_CYCLES)
                                     : STAB_CNT_W'(LONG_STAB_CYCLES);
   logic [STAB_CNT_W-1:0] holdCnt_reg;

   // Option byte sampled only while reset is held, so settings cannot shift later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opt_reg <= optionByte; // see R14 see R13
         rdp_reg <= romPart ? ~readoutProtRaw : readoutProtRaw; // see R12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign package_select_bit    = opt_reg[OPT_PKG_POS]; // see R10
   assign reset_length_select   = rstLenBit;
   assign clock_source_type     = crod_src_t'(srcField); // see R04
   // External clock ignores programmed range bits
   assign resonator_drive_range = (srcField == CROD_SRC_EXTERNAL) ? CROD_RNG_2_4
                                : crod_rng_t'(rangeField); // see R05 see R06
   assign pll_disable           = opt_reg[OPT_PLL_DISABLE_POS];
   // PLL legality with RC or other ranges is the programmer's duty, not checked here
   assign pllEnable             = ~opt_reg[OPT_PLL_DISABLE_POS]; // see R07
   // Flash encoding: 0 means protection enabled
   assign readoutProtEnable     = ~rdp_reg;
   assign unbondedPullUp        = 1'h1; // see R11

   ////////////////////////////////////////////////////////////////////////
   // The state register trails the counter by one edge, so the count loads one short
   assign stabLoad  = stabLen - 1'h1; // see R01
   assign stabStart = sys_rst | (state_reg == CROD_ST_RUN && haltWake); // see R02

   crod_stab_counter u_stab (
      .clk       (clk),
      .start     (stabStart),
      .loadCount (stabLoad),
      .busy      (stabBusy)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CROD_ST_RUN:  if (haltWake) state_next = CROD_ST_STAB;
         CROD_ST_STAB: if (!stabBusy) state_next = CROD_ST_RUN;
         // Codes 2 and 3 are never entered; fall back to a hold that ends by itself
         default:      state_next = CROD_ST_STAB;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= CROD_ST_STAB;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cpuHold = sys_rst | (state_reg == CROD_ST_STAB);

   ////////////////////////////////////////////////////////////////////////
   // Cycles spent in the current hold, read only by the checks
   always_ff @(posedge clk) begin
      if (sys_rst || !cpuHold) begin
         holdCnt_reg <= '0;
      end else begin
         holdCnt_reg <= holdCnt_reg + 1'h1;
      end
   end

   // Hold lengths are checked on the counter, since a repetition of thousands of cycles stalls the tools
   property p_long_hold;
      @(posedge clk) disable iff (sys_rst)
      (!cpuHold && holdCnt_reg != '0 && !rstLenBit) |-> holdCnt_reg == STAB_CNT_W'(LONG_STAB_CYCLES);
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long hold wrong length"); // see R01 see R02

   property p_short_len;
      @(posedge clk) disable iff (sys_rst)
      (!cpuHold && holdCnt_reg != '0 && rstLenBit) |-> holdCnt_reg == STAB_CNT_W'(SHORT_STAB_CYCLES);
   endproperty
   a_short_len: assert property (p_short_len) else $error("short hold wrong length"); // see R01 see R02

   property p_hold_max;
      @(posedge clk) disable iff (sys_rst)
      cpuHold |-> holdCnt_reg < stabLen;
   endproperty
   a_hold_max: assert property (p_hold_max) else $error("hold overran its count"); // see R01 see R02

   // Short hold also checked edge by edge, as 255 cycles stays within a plain delay
   property p_short_release;
      @(posedge clk) disable iff (sys_rst)
      ($fell(sys_rst) && rstLenBit) |-> ##255 cpuHold ##1 !cpuHold;
   endproperty
   a_short_release: assert property (p_short_release) else $error("short hold wrong"); // see R01

   property p_halt_hold;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == CROD_ST_RUN && haltWake) |=> cpuHold;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt exit not held"); // see R02

   // A hold starts only on reset or on an accepted halt exit
   property p_hold_rise;
      @(posedge clk) disable iff (sys_rst)
      (!cpuHold && !haltWake) |=> !cpuHold;
   endproperty
   a_hold_rise: assert property (p_hold_rise) else $error("hold without request"); // see R02

   // Decoded values right after reset must match the pins at the last reset edge
   property p_ext_range;
      @(posedge clk) disable iff (sys_rst)
      ($past(sys_rst) && $past(srcRaw) == CROD_SRC_EXTERNAL) |-> resonator_drive_range == CROD_RNG_2_4;
   endproperty
   a_ext_range: assert property (p_ext_range) else $error("external range not forced"); // see R06

   property p_res_range;
      @(posedge clk) disable iff (sys_rst)
      ($past(sys_rst) && $past(srcRaw) == CROD_SRC_RESONATOR) |-> resonator_drive_range == $past(rangeRaw);
   endproperty
   a_res_range: assert property (p_res_range) else $error("resonator range wrong"); // see R05

   property p_src;
      @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> clock_source_type == $past(srcRaw);
   endproperty
   a_src: assert property (p_src) else $error("source field wrong"); // see R04

   property p_pll;
      @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> pllEnable == !$past(pllOffRaw) && pll_disable == $past(pllOffRaw);
   endproperty
   a_pll: assert property (p_pll) else $error("pll enable wrong"); // see R07

   property p_latch;
      @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> package_select_bit == $past(pkgRaw) && reset_length_select == $past(rstLenRaw);
   endproperty
   a_latch: assert property (p_latch) else $error("package or length bit wrong"); // see R10 see R14

   // ROM parts store the protection bit inverted
   property p_rdp;
      @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> readoutProtEnable == ($past(romPart) ? $past(readoutProtRaw) : !$past(readoutProtRaw));
   endproperty
   a_rdp: assert property (p_rdp) else $error("protection polarity wrong"); // see R12

   property p_stable;
      @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> $stable(package_select_bit) && $stable(reset_length_select)
                          && $stable(clock_source_type) && $stable(resonator_drive_range)
                          && $stable(pllEnable) && $stable(readoutProtEnable);
   endproperty
   a_stable: assert property (p_stable) else $error("settings changed"); // see R14 see R10

   // Unbonded pads never leave the pull-up; software must not touch them
   property p_pullup;
      @(posedge clk) unbondedPullUp;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pads not pulled up"); // see R11

   // Main scenarios
   c_long:    cover property (@(posedge clk) $fell(sys_rst) && !rstLenBit);
   c_short:   cover property (@(posedge clk) $fell(sys_rst) && rstLenBit);
   c_halt:    cover property (@(posedge clk) state_reg == CROD_ST_RUN && haltWake);
   c_ext:     cover property (@(posedge clk) srcField == CROD_SRC_EXTERNAL);
   c_refused: cover property (@(posedge clk) !sys_rst && state_reg == CROD_ST_STAB && haltWake);
endmodule
`default_nettype wire

// ### verif/crod_option_prog.sv
`timescale 1ns/10ps
`default_nettype none
module crod_option_prog
   import crod_pkg::*;
(
   // Clock and mode
   input  wire logic       clk,
   input  wire logic       progMode,
   // Tool values
   input  wire logic [7:0] byteIn,
   input  wire logic       romIn,
   input  wire logic       protIn,
   // Storage
   output logic [7:0]      optionByte,
   output logic            romPart,
   output logic            readoutProtRaw
);
   logic [7:0] safeByte;
   // Reset length passes as given, the long delay is only advised
   assign safeByte = {byteIn[7:1], byteIn[0] | byteIn[3:1] != 3'h1 | byteIn[5:4] == 2'h2};
   // Unreachable outside programming mode, so junk shows then
   always_ff @(posedge clk) begin
      optionByte     <= progMode ? safeByte : ~optionByte;
      romPart        <= progMode ? romIn : ~romPart;
      readoutProtRaw <= progMode ? protIn : ~readoutProtRaw;
   end
endmodule
`default_nettype wire

// ### verif/test_clock_reset_option_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module test_clock_reset_option_decoder;
   import crod_pkg::*;
   logic       clk = 0, sys_rst = 1, haltWake = 0, romIn = 0, protIn = 0;
   logic [7:0] byteIn = 8'h00, optionByte, expByte;
   logic       romPart, readoutProtRaw, expRom, expProt;
   logic       pkgSel, rstLen, pllDis, pllEn, protEn, pullUp, cpuHold;
   crod_src_t  srcType;
   crod_rng_t  rngSel;
   int         miscompares = 0, n_checks = 0, cycles = 0, seed = 32'h5FC3, cnt;
   crod_option_prog i_crod_option_prog (.clk(clk), .progMode(sys_rst), .byteIn(byteIn), .romIn(romIn),
      .protIn(protIn), .optionByte(optionByte), .romPart(romPart), .readoutProtRaw(readoutProtRaw));
   crod_option_decoder i_crod_option_decoder (.clk(clk), .sys_rst(sys_rst), .optionByte(optionByte),
      .romPart(romPart), .readoutProtRaw(readoutProtRaw), .haltWake(haltWake), .package_select_bit(pkgSel),
      .reset_length_select(rstLen), .clock_source_type(srcType), .resonator_drive_range(rngSel),
      .pll_disable(pllDis), .pllEnable(pllEn), .readoutProtEnable(protEn), .unbondedPullUp(pullUp),
      .cpuHold(cpuHold));
   ////////////////////////////////////////////////////////////////////////////////
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 60000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(string what, logic [7:0] expV, logic [7:0] gotV);
      n_checks++;
      if (gotV !== expV) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, expV, gotV);
      end
   endtask
   // Counts falling edges until the hold drops; the cap only guards against a hang
   task automatic hold_len(string what, int n);
      cnt = 0;
      while (cpuHold === 1'b1 && cnt < 6000) begin
         @(negedge clk);
         cnt++;
      end
      n_checks++;
      if (cnt !== n) begin
         miscompares++;
         $display("wrong value %s expected %0d seen %0d", what, n, cnt);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         sys_rst = 1;
         byteIn = 8'($random(seed));
         byteIn[5:4] = i[1:0];
         byteIn[3:1] = {1'b0, i[2:1]};
         byteIn[6] = (i > 2);
         romIn = i[0];
         protIn = 1'($random(seed));
         repeat (8) @(negedge clk);
         expByte = optionByte;
         expRom = romPart;
         expProt = readoutProtRaw;
         sys_rst = 0;
         for (int j = 0; j < 2; j++) begin
            // The halt count starts one edge late, after the refused second cycle of the pulse
            hold_len(j ? "halt hold" : "reset hold", (expByte[6] ? SHORT_STAB_CYCLES : LONG_STAB_CYCLES) - j);
            chk("package", 8'(expByte[7]), 8'(pkgSel));
            chk("reset length", 8'(expByte[6]), 8'(rstLen));
            chk("source", 8'(expByte[5:4]), 8'(srcType));
            chk("range", expByte[5:4] == 2'h3 ? 8'h01 : 8'(expByte[3:1]), 8'(rngSel));
            chk("pll", {6'h00, ~expByte[0], expByte[0]}, {6'h00, pllEn, pllDis});
            chk("protection", {7'h00, expRom ? expProt : ~expProt}, 8'(protEn));
            chk("pull-up", 8'h01, 8'(pullUp));
            // First pulse is two cycles wide; its second cycle falls in the hold and is refused
            @(negedge clk);
            haltWake = 1;
            repeat (2 - j) @(negedge clk);
            haltWake = 0;
         end
         $display("test %0d done", i);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
